// file: src/srcr_map.vh
// Register map, field positions, reset values and timing counts for the reset/config bank.
// Assumes inclusion by bare name; holds definitions only.
`ifndef SRCR_MAP_VH
`define SRCR_MAP_VH
`define SRCR_ADDR_W 8
`define SRCR_OFS_SOFT_RESET 8'h03
`define SRCR_OFS_INTERFACE_CONFIGURATION_ZERO 8'h04
`define SRCR_INTERFACE_CONFIGURATION_ZERO_RESET 16'h0006
`define SRCR_BIT_SOFT_RESET 0
`define SRCR_BIT_SYNC 15
`define SRCR_BIT_FCS 14
`define SRCR_BIT_CSALIGN 13
`define SRCR_BIT_ZALIGN 12
`define SRCR_FLD_CRED_HI 11
`define SRCR_FLD_CRED_LO 10
`define SRCR_BIT_CUT 9
`define SRCR_LOW_HI 8
`define SRCR_CRED_LVL0 6'h01
`define SRCR_CRED_LVL1 6'h04
`define SRCR_CRED_LVL2 6'h08
`define SRCR_CRED_LVL3 6'h10
`define SRCR_CS_MIN_NS 100
`define SRCR_CLK_NS 10
`define SRCR_CS_MIN_CYC ((`SRCR_CS_MIN_NS + `SRCR_CLK_NS - 1) / `SRCR_CLK_NS)
`define SRCR_RST_HOLD_CYC 4
`endif

// file: src/srcr_sync2.v
// Two flip-flop synchroniser for a bundle of single-bit levels.
// Assumes inputs come from outside the core_clk_i domain.
`timescale 1ns/100ps
module srcr_sync2 #(
  parameter W = 1
) (
  input wire core_clk_i,
  input wire sys_rst_i,
  input wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;
  always @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end
    else
    begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end
  assign sync_o = sync_r;
endmodule

// file: src/srcr_regs.v
// Software reset register and upper configuration register 0 of an SPI MAC/PHY.
// Assumes an SPI command decoder supplies single-cycle register writes and reads on
// core_clk_i; chip select level arrives raw from the pin and is synchronised here.
//
// Overview of operation
// RL1 - Writing one to the soft reset trigger resets all state, PHY included.
// RL2 - The triggered reset waits until chip select deasserts.
// RL3 - Host keeps chip select asserted at least 100 ns on the trigger write.
// RL4 - The trigger bit clears itself once the reset has run.
// RL5 - The sync bit is copied into every receive footer sync flag.
// RL6 - Sync bit is write-one-to-set; only reset clears it.
// RL7 - After any reset: sync clears, reset-complete sets, interrupt asserts.
// RL8 - FCS check enable makes the device validate the last four frame octets.
// RL9 - Host must not enable MAC CRC appending while FCS check is on.
// RL10 - CS alignment starts frames only in first payload after CS, offset zero.
// RL11 - Zero alignment starts every frame at payload start, offset zero.
// RL12 - Alignment, credit threshold and CS alignment apply only under OA SPI.
// RL13 - Interrupt asserts when free credits reach threshold 1, 4, 8 or 16.
// RL14 - Transmit cut-through forwards frames before they are fully buffered.
// RL15 - Host must feed cut-through data faster than 10 Mbps.
// RL16 - Reserved bits read zero and ignore writes.
`timescale 1ns/100ps
`include "srcr_map.vh"
module srcr_regs (
  input wire core_clk_i,
  input wire sys_rst_i,
  input wire cs_n_i,
  input wire oa_spi_mode_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire [5:0] tx_free_credits_i,
  input wire reset_complete_clr_i,
  output reg [31:0] reg_rdata_o,
  output wire reg_ack_o,
  output reg soft_reset_o,
  output reg reset_complete_flag_o,
  output reg irq_o,
  output reg rx_footer_sync_o,
  output reg tx_fcs_check_enable_o,
  output reg cs_aligned_rx_enable_o,
  output reg zero_aligned_rx_enable_o,
  output reg tx_cut_through_enable_o,
  output reg [1:0] tx_credit_level_o,
  output reg [7:0] cfg_low_o
);
  localparam ST_IDLE = 2'd0;
  localparam ST_ARMED = 2'd1;
  localparam ST_RESET = 2'd2;

  wire cs_n_s;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [2:0] hold_r;
  reg [7:0] cs_cnt_r;
  reg cs_long_r;
  reg cs_prev_r;
  reg sync_bit_r;
  reg [15:0] cfg_r;
  reg [5:0] cred_need;
  reg [31:0] rdata_nxt;
  wire int_rst;
  wire trig_wr;
  wire cfg_wr;
  wire cs_rise;
  wire [31:0] cs_min_last;
  wire [31:0] hold_last;
  wire [15:0] cfg_rst_val;

  srcr_sync2 #(.W(1)) u_cs_sync (
    .core_clk_i(core_clk_i),
    .sys_rst_i(1'b0),
    .async_i(cs_n_i),
    .sync_o(cs_n_s)
  );

  // The soft reset pulse is folded into the same reset that power-on uses. [RL1]
  assign int_rst = sys_rst_i | (state_r == ST_RESET);
  assign trig_wr = reg_wr_i && (reg_addr_i == `SRCR_OFS_SOFT_RESET) &&
                   reg_wdata_i[`SRCR_BIT_SOFT_RESET];
  assign cfg_wr = reg_wr_i && (reg_addr_i == `SRCR_OFS_INTERFACE_CONFIGURATION_ZERO);
  assign cs_rise = cs_n_s && !cs_prev_r;
  assign reg_ack_o = reg_wr_i | reg_rd_i;
  // The long flag sets on the tenth synchronised low sample, so exactly 100 ns is accepted.
  assign cs_min_last = `SRCR_CS_MIN_CYC - 1;
  assign hold_last = `SRCR_RST_HOLD_CYC - 1;
  assign cfg_rst_val = `SRCR_INTERFACE_CONFIGURATION_ZERO_RESET;

  // Chip select low time is measured so a too-short frame drops the trigger.
  always @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      cs_cnt_r <= 8'h00;
      cs_long_r <= 1'b0;
      cs_prev_r <= 1'b1;
    end
    else
    begin
      cs_prev_r <= cs_n_s;
      if (cs_n_s)
      begin
        cs_cnt_r <= 8'h00;
        cs_long_r <= 1'b0;
      end
      else if (cs_cnt_r < cs_min_last[7:0])
      begin
        cs_cnt_r <= cs_cnt_r + 8'h01;
      end
      else
      begin
        cs_long_r <= 1'b1; // [RL3]
      end
    end
  end

  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
      begin
        if (trig_wr)
        begin
          state_nxt = ST_ARMED;
        end
      end
      ST_ARMED:
      begin
        // Reset is held back until chip select rises so the write completes. [RL2]
        if (cs_rise)
        begin
          state_nxt = cs_long_r ? ST_RESET : ST_IDLE;
        end
      end
      ST_RESET:
      begin
        if (hold_r == hold_last[2:0])
        begin
          state_nxt = ST_IDLE; // [RL4]
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      state_r <= ST_IDLE;
      hold_r <= 3'h0;
      soft_reset_o <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      hold_r <= (state_r == ST_RESET) ? hold_r + 3'h1 : 3'h0;
      soft_reset_o <= (state_nxt == ST_RESET); // [RL1]
    end
  end

  // Write-one-to-set sync, reserved bits dropped, all fields back to defaults.
  always @(posedge core_clk_i)
  begin
    if (int_rst)
    begin
      sync_bit_r <= 1'b0; // [RL7]
      cfg_r <= `SRCR_INTERFACE_CONFIGURATION_ZERO_RESET;
      reset_complete_flag_o <= 1'b1; // [RL7]
    end
    else
    begin
      if (cfg_wr && reg_wdata_i[`SRCR_BIT_SYNC])
      begin
        sync_bit_r <= 1'b1; // [RL6]
      end
      if (cfg_wr)
      begin
        cfg_r <= {1'b0, reg_wdata_i[`SRCR_BIT_FCS:0]}; // [RL16]
      end
      if (reset_complete_clr_i)
      begin
        reset_complete_flag_o <= 1'b0;
      end
    end
  end

  always @*
  begin
    case (cfg_r[`SRCR_FLD_CRED_HI:`SRCR_FLD_CRED_LO])
      2'b00: cred_need = `SRCR_CRED_LVL0;
      2'b01: cred_need = `SRCR_CRED_LVL1;
      2'b10: cred_need = `SRCR_CRED_LVL2;
      default: cred_need = `SRCR_CRED_LVL3; // [RL13]
    endcase
  end

  always @*
  begin
    rdata_nxt = 32'h0000_0000; // [RL16]
    if (reg_addr_i == `SRCR_OFS_INTERFACE_CONFIGURATION_ZERO)
    begin
      rdata_nxt[`SRCR_BIT_SYNC:0] = {sync_bit_r, cfg_r[`SRCR_BIT_FCS:0]};
    end
  end

  always @(posedge core_clk_i)
  begin
    if (int_rst)
    begin
      reg_rdata_o <= 32'h0000_0000;
      irq_o <= 1'b1; // [RL7]
      rx_footer_sync_o <= 1'b0;
      tx_fcs_check_enable_o <= 1'b0;
      cs_aligned_rx_enable_o <= 1'b0;
      zero_aligned_rx_enable_o <= 1'b0;
      tx_cut_through_enable_o <= 1'b0;
      tx_credit_level_o <= 2'b00;
      cfg_low_o <= cfg_rst_val[`SRCR_LOW_HI-1:0];
    end
    else
    begin
      if (reg_rd_i)
      begin
        reg_rdata_o <= rdata_nxt;
      end
      // Interrupt stays up until the complete flag is cleared, and also tracks credits under OA SPI.
      irq_o <= reset_complete_flag_o ||
               (oa_spi_mode_i && (tx_free_credits_i >= cred_need)); // [RL13] [RL12]
      rx_footer_sync_o <= sync_bit_r; // [RL5]
      tx_fcs_check_enable_o <= cfg_r[`SRCR_BIT_FCS]; // [RL8]
      cs_aligned_rx_enable_o <= oa_spi_mode_i & cfg_r[`SRCR_BIT_CSALIGN]; // [RL10] [RL12]
      zero_aligned_rx_enable_o <= oa_spi_mode_i & cfg_r[`SRCR_BIT_ZALIGN]; // [RL11] [RL12]
      tx_cut_through_enable_o <= cfg_r[`SRCR_BIT_CUT]; // [RL14]
      tx_credit_level_o <= cfg_r[`SRCR_FLD_CRED_HI:`SRCR_FLD_CRED_LO];
      cfg_low_o <= cfg_r[`SRCR_LOW_HI-1:0];
    end
  end
endmodule

// file: testbench/srcr_regs_assertions.sv
// Port checker for the reset and configuration bank.
// Assumes it is bound to srcr_regs and sees its ports by name.
`timescale 1ns/100ps
module srcr_regs_chk (
  input wire core_clk_i,
  input wire sys_rst_i,
  input wire cs_n_i,
  input wire oa_spi_mode_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire [5:0] tx_free_credits_i,
  input wire [31:0] reg_rdata_o,
  input wire soft_reset_o,
  input wire reset_complete_flag_o,
  input wire irq_o,
  input wire rx_footer_sync_o,
  input wire [1:0] tx_credit_level_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  AST_SRST_LEN: assert property (
    $rose(soft_reset_o) |-> soft_reset_o[*4] ##1 !soft_reset_o) else $error("reset length");
  AST_SRST_CS: assert property (
    $rose(soft_reset_o) |-> $past(cs_n_i) && $past(cs_n_i, 2)) else $error("reset early");
  AST_SRST_CLR: assert property (
    soft_reset_o |=> !rx_footer_sync_o && reset_complete_flag_o && irq_o) else $error("state");
  AST_SYNC_HOLD: assert property (
    rx_footer_sync_o |=> rx_footer_sync_o || soft_reset_o) else $error("sync lost");
  AST_SYNC_SET: assert property (
    reg_wr_i && reg_addr_i == 8'h04 && reg_wdata_i[15] |-> ##2 rx_footer_sync_o) else $error("sync");
  AST_RD_HI: assert property (
    reg_rd_i |=> reg_rdata_o[31:16] == 16'h0000) else $error("reserved");
  AST_RD_RST: assert property (
    reg_rd_i && reg_addr_i == 8'h03 |=> reg_rdata_o == 32'h0) else $error("reset reg");
  AST_IRQ_THR: assert property (
    !reset_complete_flag_o && !$past(reset_complete_flag_o) && $past(oa_spi_mode_i) &&
    $past(tx_credit_level_o) == 2'b11 |-> irq_o == ($past(tx_free_credits_i) > 6'h0f))
    else $error("threshold");
endmodule
bind srcr_regs srcr_regs_chk u_srcr_regs_chk (.*);

// file: testbench/srcr_host_model.sv
// Host model: drives chip select low for a commanded number of cycles.
// Assumes low_cyc_i is nonzero for one cycle to start a frame.
`timescale 1ns/100ps
module srcr_host_model (
  input wire core_clk_i,
  input wire [7:0] low_cyc_i,
  output wire cs_n_o
);
  reg [7:0] cnt_r = 8'h00;
  // Chip select stays low for the commanded count, then idles high.
  assign cs_n_o = cnt_r == 8'h00;
  always @(posedge core_clk_i)
    cnt_r <= low_cyc_i != 8'h00 ? low_cyc_i : cnt_r - {7'h00, cnt_r != 8'h00};
endmodule

// file: testbench/test_srcr_regs.sv
// Bench for the reset and configuration bank.
// Assumes the host model makes chip select frames.
`timescale 1ns/100ps
module test_srcr_regs;
  reg clk = 1'b0, rst = 1'b1, oa = 1'b0, wr = 1'b0, rd = 1'b0, clr = 1'b0, seen;
  reg [7:0] ad = 8'h00, lc = 8'h00;
  reg [31:0] wd = 32'h0;
  reg [5:0] cr = 6'h0f;
  wire cs_n, srst, flag, irq, sync, ack, fcs, csal, zal, cut;
  wire [1:0] lvl;
  wire [7:0] low;
  wire [31:0] rdat;
  integer fail_count = 0, cmp_count = 0, i;
  srcr_host_model u_srcr_host_model (.core_clk_i(clk), .low_cyc_i(lc), .cs_n_o(cs_n));
  srcr_regs u_srcr_regs (.core_clk_i(clk), .sys_rst_i(rst), .cs_n_i(cs_n), .oa_spi_mode_i(oa),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(ad), .reg_wdata_i(wd), .tx_free_credits_i(cr),
    .reset_complete_clr_i(clr), .reg_rdata_o(rdat), .reg_ack_o(ack), .soft_reset_o(srst),
    .reset_complete_flag_o(flag), .irq_o(irq), .rx_footer_sync_o(sync),
    .tx_fcs_check_enable_o(fcs), .cs_aligned_rx_enable_o(csal), .zero_aligned_rx_enable_o(zal),
    .tx_cut_through_enable_o(cut), .tx_credit_level_o(lvl), .cfg_low_o(low));
  initial
    forever #5 clk = ~clk;
  task chk(input [31:0] s, input [31:0] e);
    cmp_count = cmp_count + 1;
    if (s !== e)
    begin
      fail_count = fail_count + 1;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task finish_test;
    $display("mismatches %0d compares %0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // A write when w is set, else a read whose data must equal d.
  task acc(input w, input [7:0] a, input [31:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    ad <= a;
    wd <= d;
    @(negedge clk);
    chk(ack, 1'b1);
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    @(negedge clk);
    if (!w)
      chk(rdat, d);
  endtask
  task frame(input [7:0] n);
    @(posedge clk);
    lc <= n;
    @(posedge clk);
    lc <= 8'h00;
    acc(1'b1, 8'h03, 32'h1);
  endtask
  task t_cfg;
    acc(1'b0, 8'h04, 32'h0000_0006);
    // This host never turns on MAC CRC appending and would stream cut-through data fast enough.
    acc(1'b1, 8'h04, 32'hffff_fe06);
    acc(1'b0, 8'h04, 32'h0000_fe06);
    chk({fcs, cut}, 2'b11);
    chk({csal, zal}, 2'b00);
    chk({lvl, low}, 10'h306);
    acc(1'b1, 8'h04, 32'h0000_0006);
    acc(1'b0, 8'h04, 32'h0000_8006);
    chk({fcs, cut, lvl}, 4'h0);
    chk(sync, 1'b1);
    acc(1'b0, 8'h03, 32'h0);
  endtask
  task t_irq;
    @(posedge clk);
    clr <= 1'b1;
    oa <= 1'b1;
    acc(1'b1, 8'h04, 32'h0000_bc06);
    @(posedge clk);
    clr <= 1'b0;
    repeat (3) @(negedge clk);
    chk(irq, 1'b0);
    chk({csal, zal}, 2'b11);
    @(posedge clk);
    cr <= 6'h10;
    repeat (3) @(negedge clk);
    chk(irq, 1'b1);
    @(posedge clk);
    oa <= 1'b0;
    repeat (3) @(negedge clk);
    chk(irq, 1'b0);
    chk({csal, zal}, 2'b00);
  endtask
  // A frame one cycle short of the minimum must drop the trigger; one of the minimum must not.
  task t_swrst;
    frame(8'h09);
    seen = 1'b0;
    repeat (20)
    begin
      @(negedge clk);
      seen = seen | srst;
    end
    chk(seen, 1'b0);
    frame(8'h0a);
    repeat (7) @(negedge clk);
    chk(srst, 1'b0);
    for (i = 0; i < 12 && srst !== 1'b1; i = i + 1)
      @(negedge clk);
    chk(srst, 1'b1);
    if (srst !== 1'b1)
      finish_test;
    @(negedge clk);
    chk({sync, flag, irq}, 3'b011);
    chk({fcs, csal, zal, cut, lvl, low}, 14'h0006);
    for (i = 1; i < 9 && srst === 1'b1; i = i + 1)
      @(negedge clk);
    chk(i, 4);
    acc(1'b0, 8'h04, 32'h0000_0006);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({flag, irq, sync}, 3'b110);
    t_cfg;
    t_irq;
    t_swrst;
    finish_test;
  end
endmodule
